// ==== core/dct_consts.vh ====
// constants for the dual counter/timer with capture
// assumes: included by bare name from the core files only
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH

// =====================================================================
// register indices (byte address is four times the index)
`define DCT_IDX_BYTE_CTRL    4'h0
`define DCT_IDX_MODE_CTRL    4'h1
`define DCT_IDX_WORD_CTRL    4'h2
`define DCT_IDX_SHARED_CTRL  4'h3
`define DCT_IDX_BYTE_RLD_HI  4'h4
`define DCT_IDX_BYTE_RLD_LO  4'h5
`define DCT_IDX_WORD_RLD_LO  4'h6
`define DCT_IDX_WORD_RLD_HI  4'h7
`define DCT_IDX_WORD_CAP_LO  4'h8
`define DCT_IDX_WORD_CAP_HI  4'h9
`define DCT_IDX_BYTE_CAP_LO  4'hA
`define DCT_IDX_BYTE_CAP_HI  4'hB

// =====================================================================
// byte_timer_control and word_timer_control fields
`define DCT_CTL_ENABLE       7
`define DCT_CTL_SINGLE       6
`define DCT_CTL_TIMEOUT      5
`define DCT_CTL_CLK_HI       4
`define DCT_CTL_CLK_LO       3
`define DCT_CTL_INT_EN       1
`define DCT_CTL_PIN_SEL      0
`define DCT_CTL_RW_MASK      8'hDB

// =====================================================================
// timer_mode_control fields
`define DCT_MODE_CAPTURE     7
`define DCT_MODE_PIN_B       6
`define DCT_MODE_EDGE_HI     5
`define DCT_MODE_EDGE_LO     4
`define DCT_MODE_FILT_HI     3
`define DCT_MODE_FILT_LO     2
`define DCT_MODE_BYTE_INV    1
`define DCT_MODE_WORD_INV    0

// =====================================================================
// shared_timer_control
`define DCT_SHARED_FIXED     8'h1F
`define DCT_SHARED_RW_MASK   8'hE0

// =====================================================================
// edge modes, filter widths in system clocks, reset values
`define DCT_EDGE_NONE        2'h0
`define DCT_EDGE_RISE        2'h1
`define DCT_EDGE_FALL        2'h2
`define DCT_EDGE_BOTH        2'h3
`define DCT_FILT_W1          5'h04
`define DCT_FILT_W2          5'h08
`define DCT_FILT_W3          5'h10
`define DCT_RST_BYTE         8'h00
`define DCT_RST_WORD         16'h0000

`endif

// ==== core/dct_down_counter.v ====
// down counter with single-pass or reload operation
// assumes: tick is a one-cycle enable pulse from the same clock
`timescale 1ns/1ps
module dct_down_counter #(
  parameter W = 8
) (
  // clock and reset
  input  wire         i_clk_sys,
  input  wire         i_rst,
  // control
  input  wire         i_start,
  input  wire         i_stop,
  input  wire         i_tick,
  input  wire         i_single,
  input  wire [W-1:0] i_reload,
  // status
  output wire         o_running,
  output wire         o_tc
);

  // ===================================================================
  // counting
  reg [W-1:0] count_q;
  reg         run_q;

  assign o_running = run_q;
  assign o_tc      = run_q & i_tick & (count_q == {W{1'b0}});

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      count_q <= {W{1'b0}};
      run_q   <= 1'b0;
    end else if (i_start) begin
      // reload value is sampled only here or at terminal count
      count_q <= i_reload;
      run_q   <= 1'b1;
    end else if (i_stop) begin
      run_q <= 1'b0;
    end else if (o_tc) begin
      count_q <= i_reload;
      run_q   <= ~i_single;
    end else if (run_q && i_tick) begin
      count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ==== core/dct_input_filter.v ====
// glitch filter and edge detector for the timer input
// assumes: i_level is already synchronised to i_clk_sys
`timescale 1ns/1ps
`include "dct_consts.vh"
module dct_input_filter (
  // clock and reset
  input  wire       i_clk_sys,
  input  wire       i_rst,
  // configuration
  input  wire [1:0] i_filt_sel,
  input  wire [1:0] i_edge_mode,
  // signal
  input  wire       i_level,
  output wire       o_level,
  output wire       o_pos_edge,
  output wire       o_neg_edge
);

  // ===================================================================
  // filter: a change must hold for the chosen width before it counts
  reg  [4:0] width;
  reg  [4:0] stable_q;
  reg        level_q;
  reg        pos_q;
  reg        neg_q;
  wire       accept;

  always @* begin
    case (i_filt_sel)
      2'h1:    width = `DCT_FILT_W1;
      2'h2:    width = `DCT_FILT_W2;
      2'h3:    width = `DCT_FILT_W3;
      default: width = 5'h00;
    endcase
  end

  assign accept = (i_level != level_q) && (stable_q >= width); // see (RULE19)

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      stable_q <= 5'h00;
      level_q  <= 1'b0;
      pos_q    <= 1'b0;
      neg_q    <= 1'b0;
    end else begin
      if (i_level == level_q) begin
        stable_q <= 5'h00;
      end else if (stable_q != 5'h1F) begin
        stable_q <= stable_q + 5'h01;
      end
      if (accept) begin
        level_q <= i_level;
      end
      // one-cycle pulses, gated by the edge mode
      pos_q <= accept & i_level & i_edge_mode[0]; // see (RULE18)
      neg_q <= accept & ~i_level & i_edge_mode[1]; // see (RULE18)
    end
  end

  assign o_level    = level_q;
  assign o_pos_edge = pos_q;
  assign o_neg_edge = neg_q;

endmodule

// ==== core/dct_timer.v ====
// byte and word counter/timers with capture, Avalon-MM register slave
// assumes: input pins are asynchronous; bus master is on i_clk_sys
//
// Operation
// (RULE1) byte high capture holds count while input high
// (RULE2) byte low capture holds count while input low
// (RULE3) word capture high holds captured most significant byte
// (RULE4) word capture low holds captured least significant byte
// (RULE5) capture registers read data, writes ignored
// (RULE6) word reload high byte is read/write
// (RULE7) byte control bit 1 gates timeout interrupt
// (RULE8) byte control bit 0 routes timer to pin
// (RULE9) writing enable one starts byte timer
// (RULE10) terminal count reloads, or stops if single-pass
// (RULE11) timeout set at terminal count, write-one clears
// (RULE12) software clears status before enabling timers
// (RULE13) first count tick after enabling may be short
// (RULE14) software beware read-modify-write on status bits
// (RULE15) clock field selects byte timer input rate
// (RULE16) shared control bits 4..0 read ones, fixed
// (RULE17) shared control survives stop recovery, power-on reset only
// (RULE18) edge detector makes rising or falling pulses
// (RULE19) glitches under selected width are filtered
// (RULE20) idle byte output is inverse of mode bit
// (RULE21) word timer loads high*256+low, toggles, flags, interrupts
// (RULE22) new reload values apply at next load
// (RULE23) edge copies measurement into matching capture, restarts
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dct_consts.vh"
module dct_timer (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire        i_stop_recovery,
  // avalon-mm slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // pins
  input  wire        i_edge_input_pin_a,
  input  wire        i_edge_input_pin_b,
  input  wire        i_port_output,
  output wire        o_timer_output_pin,
  // timer outputs and interrupts
  output wire        o_byte_timer_output,
  output wire        o_word_timer_output,
  output wire        o_byte_timeout_irq,
  output wire        o_word_timeout_irq
);

  // ===================================================================
  // registers
  reg  [7:0]  byte_ctl_q;
  reg  [7:0]  mode_ctl_q;
  reg  [7:0]  word_ctl_q;
  reg  [7:0]  shared_q;
  reg  [7:0]  byte_rld_hi_q;
  reg  [7:0]  byte_rld_lo_q;
  reg  [7:0]  word_rld_lo_q;
  reg  [7:0]  word_rld_hi_q;
  reg  [7:0]  byte_cap_hi_q;
  reg  [7:0]  byte_cap_lo_q;
  reg  [15:0] word_cap_q;
  reg  [7:0]  byte_meas_q;
  reg  [15:0] word_meas_q;
  reg         byte_out_q;
  reg         word_out_q;
  reg  [2:0]  presc_q;
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  pin_a_sync_q;
  reg  [1:0]  pin_b_sync_q;
  reg  [7:0]  rdata_d;

  wire        wr_en;
  wire        byte_start;
  wire        word_start;
  wire        byte_tc;
  wire        word_tc;
  wire        byte_run;
  wire        word_run;
  wire        tick;
  wire        in_level;
  wire        pos_edge;
  wire        neg_edge;
  wire        any_edge;
  wire [7:0]  wdata;

  // ===================================================================
  // bus: one wait cycle, then read data and write take effect
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign o_avs_readdata    = rdata_q;
  assign wdata = i_avs_writedata[7:0];
  assign wr_en = i_avs_write & ack_q & i_avs_byteenable[0];

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      if (i_avs_read && !ack_q) begin
        rdata_q <= {24'h000000, rdata_d};
      end
    end
  end

  always @* begin
    case (i_avs_address)
      `DCT_IDX_BYTE_CTRL:   rdata_d = byte_ctl_q;
      `DCT_IDX_MODE_CTRL:   rdata_d = mode_ctl_q;
      `DCT_IDX_WORD_CTRL:   rdata_d = word_ctl_q;
      `DCT_IDX_SHARED_CTRL: rdata_d = shared_q | `DCT_SHARED_FIXED; // see (RULE16)
      `DCT_IDX_BYTE_RLD_HI: rdata_d = byte_rld_hi_q;
      `DCT_IDX_BYTE_RLD_LO: rdata_d = byte_rld_lo_q;
      `DCT_IDX_WORD_RLD_LO: rdata_d = word_rld_lo_q;
      `DCT_IDX_WORD_RLD_HI: rdata_d = word_rld_hi_q; // see (RULE6)
      `DCT_IDX_WORD_CAP_LO: rdata_d = word_cap_q[7:0]; // see (RULE5)
      `DCT_IDX_WORD_CAP_HI: rdata_d = word_cap_q[15:8]; // see (RULE5)
      `DCT_IDX_BYTE_CAP_LO: rdata_d = byte_cap_lo_q; // see (RULE5)
      `DCT_IDX_BYTE_CAP_HI: rdata_d = byte_cap_hi_q; // see (RULE5)
      default:              rdata_d = 8'h00;
    endcase
  end

  // ===================================================================
  // control registers
  // a write of one to enable restarts the count even if already on
  assign byte_start = wr_en & (i_avs_address == `DCT_IDX_BYTE_CTRL)
                    & wdata[`DCT_CTL_ENABLE]; // see (RULE9)
  assign word_start = wr_en & (i_avs_address == `DCT_IDX_WORD_CTRL)
                    & wdata[`DCT_CTL_ENABLE]; // see (RULE21)

  always @(posedge i_clk_sys) begin
    if (i_rst || i_stop_recovery) begin
      byte_ctl_q <= `DCT_RST_BYTE; // see (RULE8)
      word_ctl_q <= `DCT_RST_BYTE;
      mode_ctl_q <= `DCT_RST_BYTE;
    end else begin
      if (wr_en && i_avs_address == `DCT_IDX_BYTE_CTRL) begin
        byte_ctl_q <= wdata & `DCT_CTL_RW_MASK;
      end else if (byte_tc && byte_ctl_q[`DCT_CTL_SINGLE]) begin
        byte_ctl_q[`DCT_CTL_ENABLE] <= 1'b0; // see (RULE10)
      end
      // status: set wins over write-one clear
      if (byte_tc) begin
        byte_ctl_q[`DCT_CTL_TIMEOUT] <= 1'b1; // see (RULE11)
      end else if (wr_en && i_avs_address == `DCT_IDX_BYTE_CTRL) begin
        byte_ctl_q[`DCT_CTL_TIMEOUT] <= byte_ctl_q[`DCT_CTL_TIMEOUT]
                                      & ~wdata[`DCT_CTL_TIMEOUT];
      end
      if (wr_en && i_avs_address == `DCT_IDX_WORD_CTRL) begin
        word_ctl_q <= wdata & `DCT_CTL_RW_MASK;
      end else if (word_tc && word_ctl_q[`DCT_CTL_SINGLE]) begin
        word_ctl_q[`DCT_CTL_ENABLE] <= 1'b0;
      end
      if (word_tc) begin
        word_ctl_q[`DCT_CTL_TIMEOUT] <= 1'b1; // see (RULE21)
      end else if (wr_en && i_avs_address == `DCT_IDX_WORD_CTRL) begin
        word_ctl_q[`DCT_CTL_TIMEOUT] <= word_ctl_q[`DCT_CTL_TIMEOUT]
                                      & ~wdata[`DCT_CTL_TIMEOUT];
      end
      if (wr_en && i_avs_address == `DCT_IDX_MODE_CTRL) begin
        mode_ctl_q <= wdata;
      end
    end
  end

  // shared control and reload holds survive stop recovery
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      shared_q      <= `DCT_RST_BYTE; // see (RULE17)
      byte_rld_hi_q <= `DCT_RST_BYTE;
      byte_rld_lo_q <= `DCT_RST_BYTE;
      word_rld_lo_q <= `DCT_RST_BYTE;
      word_rld_hi_q <= `DCT_RST_BYTE;
    end else if (wr_en) begin
      case (i_avs_address)
        `DCT_IDX_SHARED_CTRL: shared_q <= wdata & `DCT_SHARED_RW_MASK;
        `DCT_IDX_BYTE_RLD_HI: byte_rld_hi_q <= wdata;
        `DCT_IDX_BYTE_RLD_LO: byte_rld_lo_q <= wdata;
        `DCT_IDX_WORD_RLD_LO: word_rld_lo_q <= wdata; // see (RULE22)
        `DCT_IDX_WORD_RLD_HI: word_rld_hi_q <= wdata; // see (RULE6)
        default: ;
      endcase
    end
  end

  // ===================================================================
  // count clock: free prescaler, so the first tick lands anywhere
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      presc_q <= 3'h0;
    end else begin
      presc_q <= presc_q + 3'h1; // see (RULE13)
    end
  end

  reg tick_r;
  always @* begin
    case (byte_ctl_q[`DCT_CTL_CLK_HI:`DCT_CTL_CLK_LO]) // see (RULE15)
      2'h0:    tick_r = 1'b1;
      2'h1:    tick_r = presc_q[0];
      2'h2:    tick_r = &presc_q[1:0];
      default: tick_r = &presc_q;
    endcase
  end
  assign tick = tick_r;

  // ===================================================================
  // counters
  dct_down_counter #(.W(8)) u_byte_cnt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst | i_stop_recovery),
    .i_start   (byte_start),
    .i_stop    (~byte_ctl_q[`DCT_CTL_ENABLE] & ~byte_start),
    .i_tick    (tick),
    .i_single  (byte_ctl_q[`DCT_CTL_SINGLE]), // see (RULE10)
    .i_reload  (byte_rld_lo_q),
    .o_running (byte_run),
    .o_tc      (byte_tc)
  );

  dct_down_counter #(.W(16)) u_word_cnt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst | i_stop_recovery),
    .i_start   (word_start),
    .i_stop    (~word_ctl_q[`DCT_CTL_ENABLE] & ~word_start),
    .i_tick    (tick),
    .i_single  (word_ctl_q[`DCT_CTL_SINGLE]),
    .i_reload  ({word_rld_hi_q, word_rld_lo_q}), // see (RULE21)
    .o_running (word_run),
    .o_tc      (word_tc)
  );

  // ===================================================================
  // outputs: idle level is the inverse of the mode bit, toggle at tc
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      byte_out_q <= 1'b1;
      word_out_q <= 1'b1;
    end else begin
      if (byte_start || !byte_run) begin
        byte_out_q <= ~mode_ctl_q[`DCT_MODE_BYTE_INV]; // see (RULE20)
      end else if (byte_tc) begin
        byte_out_q <= ~byte_out_q;
      end
      if (word_start || !word_run) begin
        word_out_q <= ~mode_ctl_q[`DCT_MODE_WORD_INV];
      end else if (word_tc) begin
        word_out_q <= ~word_out_q; // see (RULE21)
      end
    end
  end

  assign o_byte_timer_output = byte_out_q;
  assign o_word_timer_output = word_out_q;
  assign o_timer_output_pin  = byte_ctl_q[`DCT_CTL_PIN_SEL] ? byte_out_q
                             : i_port_output; // see (RULE8)
  assign o_byte_timeout_irq  = byte_ctl_q[`DCT_CTL_TIMEOUT]
                             & byte_ctl_q[`DCT_CTL_INT_EN]; // see (RULE7)
  assign o_word_timeout_irq  = word_ctl_q[`DCT_CTL_TIMEOUT]
                             & word_ctl_q[`DCT_CTL_INT_EN]; // see (RULE21)

  // ===================================================================
  // input path: synchronise both pins, then select one
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      pin_a_sync_q <= 2'h0;
      pin_b_sync_q <= 2'h0;
    end else begin
      pin_a_sync_q <= {pin_a_sync_q[0], i_edge_input_pin_a};
      pin_b_sync_q <= {pin_b_sync_q[0], i_edge_input_pin_b};
    end
  end

  dct_input_filter u_filter (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_filt_sel  (mode_ctl_q[`DCT_MODE_FILT_HI:`DCT_MODE_FILT_LO]),
    .i_edge_mode (mode_ctl_q[`DCT_MODE_EDGE_HI:`DCT_MODE_EDGE_LO]),
    .i_level     (mode_ctl_q[`DCT_MODE_PIN_B] ? pin_b_sync_q[1]
                                              : pin_a_sync_q[1]),
    .o_level     (in_level),
    .o_pos_edge  (pos_edge),
    .o_neg_edge  (neg_edge)
  );

  // ===================================================================
  // capture: measurement counts ticks, saturating, per input phase
  assign any_edge = (pos_edge | neg_edge) & mode_ctl_q[`DCT_MODE_CAPTURE];

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      byte_meas_q   <= `DCT_RST_BYTE;
      word_meas_q   <= `DCT_RST_WORD;
      byte_cap_hi_q <= `DCT_RST_BYTE;
      byte_cap_lo_q <= `DCT_RST_BYTE;
      word_cap_q    <= `DCT_RST_WORD;
    end else if (any_edge) begin
      // rising edge ends a low phase, falling edge ends a high phase
      if (pos_edge) begin
        byte_cap_lo_q <= byte_meas_q; // see (RULE2)
      end else begin
        byte_cap_hi_q <= byte_meas_q; // see (RULE1)
      end
      word_cap_q  <= word_meas_q; // see (RULE3) (RULE4) (RULE23)
      byte_meas_q <= `DCT_RST_BYTE; // see (RULE23)
      word_meas_q <= `DCT_RST_WORD;
    end else if (tick) begin
      if (byte_meas_q != 8'hFF) begin
        byte_meas_q <= byte_meas_q + 8'h01;
      end
      if (word_meas_q != 16'hFFFF) begin
        word_meas_q <= word_meas_q + 16'h0001;
      end
    end
  end

endmodule

// ==== test/dct_props.sv ====
// concurrent checks on the counter/timer register slave and pins
// assumes: bound to dct_timer, one clock, synchronous reset
`timescale 1ns/1ps
module dct_props (
  // clock and reset
  input wire        i_clk_sys,
  input wire        i_rst,
  input wire        i_stop_recovery,
  // bus
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  // pins and timer outputs
  input wire        i_port_output,
  input wire        o_timer_output_pin,
  input wire        o_byte_timer_output,
  input wire        o_word_timer_output,
  input wire        o_byte_timeout_irq,
  input wire        o_word_timeout_irq
);
  // =====================================================================
  // shadow of the byte control bits that the pins depend on
  wire rq    = i_avs_read | i_avs_write;
  wire rd_ok = i_avs_read & ~o_avs_waitrequest;
  wire wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire wr_c0 = wr_ok && (i_avs_address == 4'h0);
  reg  sel_q;
  reg  ien_q;
  always @(posedge i_clk_sys) begin
    if (i_rst | i_stop_recovery) begin
      sel_q <= 1'b0;
      ien_q <= 1'b0;
    end else if (wr_c0) begin
      sel_q <= i_avs_writedata[0];
      ien_q <= i_avs_writedata[1];
    end
  end

  // =====================================================================
  // assertions
  default clocking dct_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_one_wait: assert property (rq && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer later than one wait cycle");
  a_no_idle_wait: assert property (!rq |-> !o_avs_waitrequest)
    else $error("waitrequest high with no request");
  a_rdata_narrow: assert property (rd_ok |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_fixed_ones: assert property (
    rd_ok && i_avs_address == 4'h3 |-> o_avs_readdata[4:0] == 5'h1F)
    else $error("shared control low bits not all ones");
  a_unmapped_zero: assert property (
    rd_ok && i_avs_address >= 4'hC |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_pin_route: assert property (
    o_timer_output_pin == (sel_q ? o_byte_timer_output : i_port_output))
    else $error("timer pin shows wrong source");
  a_irq_gated: assert property (!ien_q |-> !o_byte_timeout_irq)
    else $error("byte irq high while masked");
  a_status_holds: assert property (
    o_byte_timeout_irq && !i_stop_recovery && !wr_c0 |=> o_byte_timeout_irq)
    else $error("timeout status dropped without a write");
  a_reset_idle: assert property ($fell(i_rst) |->
    o_byte_timer_output && o_word_timer_output &&
    !o_byte_timeout_irq && !o_word_timeout_irq)
    else $error("timer outputs not idle after reset");
  a_rdata_stands: assert property (
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");

  c_read: cover property (rd_ok);
  c_irq: cover property ($rose(o_byte_timeout_irq));
  c_word: cover property ($changed(o_word_timer_output));
endmodule

bind dct_timer dct_props u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_stop_recovery(i_stop_recovery),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_port_output(i_port_output),
  .o_timer_output_pin(o_timer_output_pin),
  .o_byte_timer_output(o_byte_timer_output),
  .o_word_timer_output(o_word_timer_output),
  .o_byte_timeout_irq(o_byte_timeout_irq),
  .o_word_timeout_irq(o_word_timeout_irq)
);

// ==== test/dct_sig_source.sv ====
// external digital source driving the two edge input pins
// assumes: hold() is called from the bench just after a clock edge
`timescale 1ns/1ps
module dct_sig_source (
  // clock
  input  wire  i_clk_sys,
  // pins
  output logic o_pin_a,
  output logic o_pin_b
);
  // =====================================================================
  // push-pull source: levels move just after an edge, never glide
  initial begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  end
  task automatic hold(input bit sel_b, input logic lvl, input int n);
    if (sel_b)
      o_pin_b <= lvl;
    else
      o_pin_a <= lvl;
    repeat (n) @(posedge i_clk_sys);
  endtask
endmodule

// ==== test/dct_timer_test.sv ====
// self-checking bench for the dual counter/timer with capture
// assumes: dct_timer, dct_sig_source and dct_props compiled before
`timescale 1ns/1ps
module dct_timer_test;
  // =====================================================================
  // stimulus and observed signals
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        srec = 1'b0;
  logic [3:0]  adr  = 4'h0;
  logic        rd   = 1'b0;
  logic        wr   = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be   = 4'h0;
  logic        pout = 1'b0;
  logic [31:0] rdat;
  logic        wreq, pa, pb, pin, bout, wout, birq, wirq;
  logic [7:0]  v;
  int          fails  = 0;
  int          checks = 0;
  int          cyc    = 0;
  int          n;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    logic [3:0] b;
    logic [7:0] e;
  } dct_row_t;
  dct_row_t rows [9] = '{
    '{4'h7, 8'hA5, 4'h1, 8'hA5}, '{4'h7, 8'h5A, 4'h0, 8'hA5},
    '{4'h3, 8'h00, 4'h1, 8'h1F}, '{4'h3, 8'hFF, 4'h1, 8'hFF},
    '{4'hB, 8'hFF, 4'h1, 8'h00}, '{4'hA, 8'hFF, 4'h1, 8'h00},
    '{4'h9, 8'hFF, 4'h1, 8'h00}, '{4'h8, 8'hFF, 4'h1, 8'h00},
    '{4'hC, 8'hFF, 4'h1, 8'h00}};

  always #12.5 clk = ~clk;

  dct_timer uut (
    .i_clk_sys(clk), .i_rst(rst), .i_stop_recovery(srec),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_edge_input_pin_a(pa), .i_edge_input_pin_b(pb),
    .i_port_output(pout), .o_timer_output_pin(pin),
    .o_byte_timer_output(bout), .o_word_timer_output(wout),
    .o_byte_timeout_irq(birq), .o_word_timeout_irq(wirq));
  dct_sig_source src (.i_clk_sys(clk), .o_pin_a(pa), .o_pin_b(pb));

  // =====================================================================
  // tasks
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one transfer; holds everything until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    rd   <= ~w;
    wr   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    be   <= b;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // cycles until the chosen timer output changes, 600 if it never does
  task automatic wait_tog(input bit wd, output int k);
    logic last;
    last = wd ? wout : bout;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (k < 600 && (wd ? wout : bout) === last);
  endtask

  // the global timeout stands in for every unbounded bus wait
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
      bus(1'b0, rows[i].a, 8'h00, 4'h0);
      check(16'(v), 16'(rows[i].e), "readback");
    end
    $display("register table done");
    pout <= 1'b1;
    repeat (2) @(posedge clk);
    check(16'(pin), 16'h1, "port pin");
    check(16'({bout, wout}), 16'h3, "idle outputs");
    bus(1'b1, 4'h1, 8'h03, 4'h1);
    repeat (2) @(posedge clk);
    check(16'({bout, wout}), 16'h0, "inverted idle");
    srec <= 1'b1;
    @(posedge clk);
    srec <= 1'b0;
    bus(1'b0, 4'h3, 8'h00, 4'h0);
    check(16'(v), 16'hFF, "shared after recovery");
    $display("idle and recovery done");
    // capture: both edges on pin a with no filter, then widest filter, pin b, rise only
    bus(1'b1, 4'h1, 8'hB0, 4'h1);
    src.hold(1'b0, 1'b1, 20);
    src.hold(1'b0, 1'b0, 12);
    src.hold(1'b0, 1'b1, 40);
    bus(1'b0, 4'hB, 8'h00, 4'h0);
    check(16'(v >= 8'h13 && v <= 8'h14), 16'h1, "high time");
    bus(1'b0, 4'hA, 8'h00, 4'h0);
    check(16'(v >= 8'h0B && v <= 8'h0C), 16'h1, "low time");
    bus(1'b0, 4'h8, 8'h00, 4'h0);
    check(16'(v >= 8'h0B && v <= 8'h0C), 16'h1, "word low");
    bus(1'b0, 4'h9, 8'h00, 4'h0);
    check(16'(v), 16'h0, "word high");
    bus(1'b1, 4'h1, 8'hBC, 4'h1);
    src.hold(1'b0, 1'b0, 5);
    src.hold(1'b0, 1'b1, 40);
    bus(1'b0, 4'hB, 8'h00, 4'h0);
    check(16'(v >= 8'h13 && v <= 8'h14), 16'h1, "glitch");
    bus(1'b1, 4'h1, 8'hF0, 4'h1);
    src.hold(1'b1, 1'b1, 9);
    src.hold(1'b1, 1'b0, 30);
    bus(1'b0, 4'hB, 8'h00, 4'h0);
    check(16'(v >= 8'h08 && v <= 8'h09), 16'h1, "pin b");
    bus(1'b1, 4'h1, 8'hD0, 4'h1);
    src.hold(1'b1, 1'b1, 20);
    src.hold(1'b1, 1'b0, 30);
    bus(1'b0, 4'hB, 8'h00, 4'h0);
    check(16'(v >= 8'h08 && v <= 8'h09), 16'h1, "rise only");
    bus(1'b1, 4'h1, 8'h00, 4'h1);
    $display("capture done");
    // byte timer: reload 3 gives four ticks a period
    bus(1'b1, 4'h5, 8'h03, 4'h1);
    bus(1'b1, 4'h0, 8'h20, 4'h1);
    bus(1'b1, 4'h0, 8'h83, 4'h1);
    wait_tog(1'b0, n);
    wait_tog(1'b0, n);
    check(16'(n), 16'h4, "modulo period");
    check(16'({pin, birq}), 16'({bout, 1'b1}), "pin and irq");
    bus(1'b1, 4'h0, 8'h8B, 4'h1);
    wait_tog(1'b0, n);
    wait_tog(1'b0, n);
    check(16'(n), 16'h8, "divided period");
    bus(1'b1, 4'h0, 8'hC2, 4'h1);
    wait_tog(1'b0, n);
    repeat (20) @(posedge clk);
    wait_tog(1'b0, n);
    check(16'(n), 16'd600, "single stops");
    bus(1'b0, 4'h0, 8'h00, 4'h0);
    check(16'(v), 16'h62, "status set");
    bus(1'b1, 4'h0, 8'h22, 4'h1);
    bus(1'b0, 4'h0, 8'h00, 4'h0);
    check(16'({v, 7'h0, birq}), 16'h0200, "status cleared");
    $display("byte timer done");
    // word timer: 0x0002 then 0x0100
    bus(1'b1, 4'h6, 8'h02, 4'h1);
    bus(1'b1, 4'h7, 8'h00, 4'h1);
    bus(1'b1, 4'h2, 8'h80, 4'h1);
    wait_tog(1'b1, n);
    wait_tog(1'b1, n);
    check(16'(n), 16'h3, "word period");
    bus(1'b1, 4'h7, 8'h01, 4'h1);
    bus(1'b1, 4'h6, 8'h00, 4'h1);
    wait_tog(1'b1, n);
    wait_tog(1'b1, n);
    wait_tog(1'b1, n);
    check(16'(n), 16'd257, "word reload");
    $display("word timer done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h00, 4'h0);
    check(16'({v, bout, wout}), 16'h0003, "second reset");
    $display("reset done");
    wrap_up();
  end
endmodule
